// >>> fthr_pkg.sv
// fault threshold configuration: shared constants, field layout, fsm states
// assumes a single 25 MHz clock domain and a serial management bus slave
package fthr_pkg;

  // ==========================================================
  // register command codes
  localparam logic [7:0]  CMD_OV_LIMIT      = 8'hda;
  localparam logic [7:0]  CMD_UV_LIMIT      = 8'hdb;
  localparam logic [7:0]  CMD_OC_LIMIT      = 8'hdc;

  // ==========================================================
  // reset values and writable bit masks
  localparam logic [15:0] OV_LIMIT_RESET    = 16'h003f;
  localparam logic [7:0]  UV_LIMIT_RESET    = 8'h00;
  localparam logic [15:0] OC_LIMIT_RESET    = 16'h003f;
  localparam logic [15:0] OV_LIMIT_WMASK    = 16'h03ff;
  localparam logic [7:0]  UV_LIMIT_WMASK    = 8'h3f;
  localparam logic [15:0] OC_LIMIT_WMASK    = 16'h027f;

  // ==========================================================
  // field positions
  localparam int          SRC_SEL_BIT       = 9;
  localparam int          RANGE_LSB         = 6;
  localparam int          RANGE_W           = 3;
  localparam int          LEVEL_W           = 6;
  localparam int          DIR_BIT           = 9;
  localparam int          SHUNT_RANGE_BIT   = 6;

  // ==========================================================
  // threshold scaling: one level step is 1/64 of full scale
  localparam logic [6:0]  HIGH_BASE_STEPS   = 7'h10;
  localparam logic [6:0]  LOW_BASE_STEPS    = 7'h00;
  localparam int          STEP_SHIFT        = 6;

  // full scales in mV, 60 V variant then 12 V variant
  localparam logic [16:0] FS60_CODE0_MV     = 17'h0bb80;
  localparam logic [16:0] FS60_CODE1_MV     = 17'h05dc0;
  localparam logic [16:0] FS60_CODE2_MV     = 17'h02ee0;
  localparam logic [16:0] FS60_CODE3_MV     = 17'h01388;
  localparam logic [16:0] FS60_CODE4_MV     = 17'h00ce4;
  localparam logic [16:0] FS60_CODE5_MV     = 17'h009c4;
  localparam logic [16:0] FS12_CODE0_MV     = 17'h02ee0;
  localparam logic [16:0] FS12_CODE1_MV     = 17'h01770;
  localparam logic [16:0] FS12_CODE2_MV     = 17'h00bb8;
  localparam logic [16:0] FS12_CODE3_MV     = 17'h004e2;

  // shunt full scales in uV
  localparam logic [16:0] SHUNT_FS_WIDE_UV  = 17'h13880;
  localparam logic [16:0] SHUNT_FS_NARROW_UV = 17'h09c40;

  // temperature level in units of 0.01 C
  localparam logic signed [16:0] TEMP_BASE_CC = -17'sh03840;
  localparam logic [16:0] TEMP_STEP_CC      = 17'h0023b;

  // ==========================================================
  // serial bus
  localparam logic [3:0]  BYTE_BITS         = 4'h8;

  typedef enum logic [8:0] {
    S_IDLE     = 9'h001,
    S_ADDR     = 9'h002,
    S_ADDR_ACK = 9'h004,
    S_CMD      = 9'h008,
    S_CMD_ACK  = 9'h010,
    S_WDATA    = 9'h020,
    S_WDATA_ACK = 9'h040,
    S_RDATA    = 9'h080,
    S_RACK     = 9'h100
  } fthr_state_t;

endpackage

// >>> fthr_limit_if.sv
// limit settings carried from the register bank to the comparator logic
// assumes one driver module and one consumer module
`timescale 1ns/10ps
interface fthr_limit_if;
  logic       high_limit_source_select;
  logic [2:0] range_code;
  logic [5:0] high_limit_level;
  logic [5:0] low_limit_level;
  logic       shunt_dir;
  logic       shunt_range;
  logic [5:0] shunt_limit_level;

  modport cfg (
    output high_limit_source_select,
    output range_code,
    output high_limit_level,
    output low_limit_level,
    output shunt_dir,
    output shunt_range,
    output shunt_limit_level
  );
  modport cmp (
    input  high_limit_source_select,
    input  range_code,
    input  high_limit_level,
    input  low_limit_level,
    input  shunt_dir,
    input  shunt_range,
    input  shunt_limit_level
  );
endinterface

// >>> fthr_compare.sv
// digital threshold comparators for high limit, low limit and shunt limit
// assumes measurements arrive synchronous to ref_clk in mV, 0.01 C and uV
`timescale 1ns/10ps
module fthr_compare
  import fthr_pkg::*;
#(
  parameter bit VARIANT_60V = 1'b1
) (
  input  wire logic               ref_clk,
  input  wire logic               rst,
  fthr_limit_if.cmp               lim,
  input  wire logic [15:0]        bus_voltage_mv,
  input  wire logic signed [15:0] die_temp_cc,
  input  wire logic [26:0]        shunt_input_pos,
  input  wire logic [26:0]        shunt_input_neg,
  output logic                    high_trip_q,
  output logic                    low_trip_q,
  output logic                    shunt_trip_q
);

  function automatic logic [16:0] fthr_scale(input logic [16:0] fs, input logic [6:0] steps);
    logic [23:0] prod;
    prod = {7'h00, fs} * {17'h00000, steps};
    return prod[STEP_SHIFT+16:STEP_SHIFT];
  endfunction

  // ==========================================================
  // reference levels
  logic        fs_valid;
  logic [16:0] fs_mv;
  logic [16:0] high_thr_mv;
  logic [16:0] low_thr_mv;
  logic [16:0] shunt_fs_uv;
  logic [16:0] shunt_thr_uv;
  logic signed [16:0] temp_thr_cc;
  logic signed [27:0] shunt_diff;
  logic signed [27:0] shunt_mag;
  logic        high_trip_d;
  logic        low_trip_d;
  logic        shunt_trip_d;

  always_comb begin
    fs_valid = 1'b1;
    fs_mv    = 17'h00000;
    if (VARIANT_60V) begin
      unique case (lim.range_code) // [RULE_04]
        3'h0:    fs_mv = FS60_CODE0_MV;
        3'h1:    fs_mv = FS60_CODE1_MV;
        3'h2:    fs_mv = FS60_CODE2_MV;
        3'h3:    fs_mv = FS60_CODE3_MV;
        3'h4:    fs_mv = FS60_CODE4_MV;
        3'h5:    fs_mv = FS60_CODE5_MV;
        default: fs_valid = 1'b0;
      endcase
    end else begin
      unique case (lim.range_code) // [RULE_05]
        3'h0:    fs_mv = FS12_CODE0_MV;
        3'h1:    fs_mv = FS12_CODE1_MV;
        3'h2:    fs_mv = FS12_CODE2_MV;
        3'h3:    fs_mv = FS12_CODE3_MV;
        default: fs_valid = 1'b0;
      endcase
    end
    // one range field scales both voltage references
    high_thr_mv = fthr_scale(fs_mv,
      HIGH_BASE_STEPS + {1'b0, lim.high_limit_level}); // [RULE_03] [RULE_06]
    low_thr_mv  = fthr_scale(fs_mv,
      LOW_BASE_STEPS + {1'b0, lim.low_limit_level}); // [RULE_03] [RULE_09]
    temp_thr_cc = TEMP_BASE_CC
                  + $signed(17'(TEMP_STEP_CC * {11'h000, lim.high_limit_level})); // [RULE_07]
    shunt_fs_uv = lim.shunt_range ? SHUNT_FS_NARROW_UV : SHUNT_FS_WIDE_UV; // [RULE_12]
    shunt_thr_uv = fthr_scale(shunt_fs_uv,
      HIGH_BASE_STEPS + {1'b0, lim.shunt_limit_level}); // [RULE_13]
    shunt_diff  = $signed({1'b0, shunt_input_pos}) - $signed({1'b0, shunt_input_neg});
    shunt_mag   = lim.shunt_dir ? -shunt_diff : shunt_diff; // [RULE_11]
    if (lim.high_limit_source_select) begin
      high_trip_d = $signed({die_temp_cc[15], die_temp_cc}) > temp_thr_cc; // [RULE_02]
    end else begin
      high_trip_d = fs_valid && ({1'b0, bus_voltage_mv} > high_thr_mv); // [RULE_02]
    end
    low_trip_d   = fs_valid && ({1'b0, bus_voltage_mv} < low_thr_mv);
    shunt_trip_d = shunt_mag > $signed({11'h000, shunt_thr_uv});
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      high_trip_q  <= 1'b0;
      low_trip_q   <= 1'b0;
      shunt_trip_q <= 1'b0;
    end else begin
      high_trip_q  <= high_trip_d;
      low_trip_q   <= low_trip_d;
      shunt_trip_q <= shunt_trip_d;
    end
  end

endmodule

// >>> fthr_config.sv
// fault threshold register bank with serial management bus slave and alert pins
// assumes scl and sda_i synchronous to ref_clk; sda wired-and outside
//
// Functional notes
// [RULE_01] high limit register: source, range, level fields
// [RULE_02] source bit picks temperature or bus voltage
// [RULE_03] one range field scales both voltage references
// [RULE_04] 60 V ranges: 48, 24, 12, 5, 3.3, 2.5
// [RULE_05] 12 V ranges: 12, 6, 3, 1.25 only
// [RULE_06] high voltage level: 25% plus 1/64 steps
// [RULE_07] temperature level: -144 C plus 5.71 C steps
// [RULE_08] low limit byte register, level code, resets zero
// [RULE_09] low level: code times 1/64 full scale
// [RULE_10] shunt limit register: direction, range, level fields
// [RULE_11] direction bit picks shunt polarity checked
// [RULE_12] shunt range bit: 80 mV or 40 mV
// [RULE_13] shunt level: 25% plus 1/64 steps
// [RULE_14] comparator results drive both alert pins
// [RULE_15] unused bits read zero, ignore writes
`timescale 1ns/10ps
module fthr_config
  import fthr_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR  = 7'h40, // value arbitrary
  parameter bit         VARIANT_60V = 1'b1
) (
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic               scl,
  input  wire logic               sda_i,
  output logic                    sda_o,
  output logic                    sda_oe_n,
  input  wire logic [15:0]        bus_voltage_mv,
  input  wire logic signed [15:0] die_temp_cc,
  input  wire logic [26:0]        shunt_input_pos,
  input  wire logic [26:0]        shunt_input_neg,
  output logic                    alert_out_one_o,
  output logic                    alert_out_one_oe_n,
  output logic                    alert_out_two_n
);

  // ==========================================================
  // helpers
  function automatic logic fthr_cmd_hit(input logic [7:0] cmd);
    return (cmd == CMD_OV_LIMIT) || (cmd == CMD_UV_LIMIT) || (cmd == CMD_OC_LIMIT);
  endfunction

  function automatic logic [1:0] fthr_cmd_bytes(input logic [7:0] cmd);
    return (cmd == CMD_UV_LIMIT) ? 2'h1 : 2'h2;
  endfunction

  function automatic logic [7:0] fthr_rd_byte(
    input logic [7:0]  cmd,
    input logic        hit,
    input logic [1:0]  idx,
    input logic [15:0] ov,
    input logic [7:0]  uv,
    input logic [15:0] oc
  );
    logic [15:0] word;
    word = 16'hffff;
    if (hit) begin
      if (cmd == CMD_OV_LIMIT) begin
        word = ov;
      end else if (cmd == CMD_UV_LIMIT) begin
        word = {8'h00, uv};
      end else begin
        word = oc;
      end
    end
    return (idx == 2'h0) ? word[7:0] : word[15:8];
  endfunction

  // ==========================================================
  // bus state
  fthr_state_t state_q;
  fthr_state_t state_d;
  logic        scl_prev_q;
  logic        sda_prev_q;
  logic [3:0]  bit_cnt_q;
  logic [3:0]  bit_cnt_d;
  logic [7:0]  shift_q;
  logic [7:0]  shift_d;
  logic [7:0]  cmd_q;
  logic [7:0]  cmd_d;
  logic        cmd_hit_q;
  logic        cmd_hit_d;
  logic [1:0]  byte_idx_q;
  logic [1:0]  byte_idx_d;
  logic [7:0]  low_byte_q;
  logic [7:0]  low_byte_d;
  logic        master_ack_q;
  logic        master_ack_d;
  logic        sda_oe_n_q;
  logic        sda_oe_n_d;
  logic [15:0] ov_limit_q;
  logic [15:0] ov_limit_d;
  logic [7:0]  uv_limit_q;
  logic [7:0]  uv_limit_d;
  logic [15:0] oc_limit_q;
  logic [15:0] oc_limit_d;

  logic        scl_rise;
  logic        scl_fall;
  logic        start_seen;
  logic        stop_seen;
  logic [7:0]  rx_byte;
  logic [7:0]  tx_byte;

  assign scl_rise   = scl & ~scl_prev_q;
  assign scl_fall   = ~scl & scl_prev_q;
  assign start_seen = scl & scl_prev_q & sda_prev_q & ~sda_i;
  assign stop_seen  = scl & scl_prev_q & ~sda_prev_q & sda_i;
  assign rx_byte    = shift_q;

  // ==========================================================
  // bus next state
  always_comb begin
    state_d      = state_q;
    bit_cnt_d    = bit_cnt_q;
    shift_d      = shift_q;
    cmd_d        = cmd_q;
    cmd_hit_d    = cmd_hit_q;
    byte_idx_d   = byte_idx_q;
    low_byte_d   = low_byte_q;
    master_ack_d = master_ack_q;
    sda_oe_n_d   = sda_oe_n_q;
    ov_limit_d   = ov_limit_q;
    uv_limit_d   = uv_limit_q;
    oc_limit_d   = oc_limit_q;
    tx_byte      = 8'h00;
    if (start_seen) begin
      state_d    = S_ADDR;
      bit_cnt_d  = 4'h0;
      sda_oe_n_d = 1'b1;
    end else if (stop_seen) begin
      state_d    = S_IDLE;
      sda_oe_n_d = 1'b1;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          sda_oe_n_d = 1'b1;
        end
        S_ADDR: begin
          if (scl_rise) begin
            shift_d   = {shift_q[6:0], sda_i};
            bit_cnt_d = bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == BYTE_BITS) begin
            bit_cnt_d = 4'h0;
            if (rx_byte[7:1] == SLAVE_ADDR) begin
              state_d      = S_ADDR_ACK;
              master_ack_d = rx_byte[0];
              sda_oe_n_d   = 1'b0;
            end else begin
              state_d = S_IDLE;
            end
          end
        end
        S_ADDR_ACK: begin
          if (scl_fall) begin
            bit_cnt_d  = 4'h0;
            byte_idx_d = 2'h0;
            if (master_ack_q) begin
              tx_byte    = fthr_rd_byte(cmd_q, cmd_hit_q, 2'h0, ov_limit_q, uv_limit_q,
                                        oc_limit_q);
              shift_d    = tx_byte;
              sda_oe_n_d = tx_byte[7];
              state_d    = S_RDATA;
            end else begin
              sda_oe_n_d = 1'b1;
              state_d    = S_CMD;
            end
          end
        end
        S_CMD: begin
          if (scl_rise) begin
            shift_d   = {shift_q[6:0], sda_i};
            bit_cnt_d = bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == BYTE_BITS) begin
            bit_cnt_d  = 4'h0;
            cmd_d      = rx_byte;
            cmd_hit_d  = fthr_cmd_hit(rx_byte);
            byte_idx_d = 2'h0;
            if (fthr_cmd_hit(rx_byte)) begin
              sda_oe_n_d = 1'b0;
              state_d    = S_CMD_ACK;
            end else begin
              state_d = S_IDLE;
            end
          end
        end
        S_CMD_ACK: begin
          if (scl_fall) begin
            sda_oe_n_d = 1'b1;
            state_d    = S_WDATA;
          end
        end
        S_WDATA: begin
          if (scl_rise) begin
            shift_d   = {shift_q[6:0], sda_i};
            bit_cnt_d = bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == BYTE_BITS) begin
            bit_cnt_d = 4'h0;
            if (byte_idx_q >= fthr_cmd_bytes(cmd_q)) begin
              state_d = S_IDLE;
            end else begin
              sda_oe_n_d = 1'b0;
              state_d    = S_WDATA_ACK;
              byte_idx_d = byte_idx_q + 2'h1;
              low_byte_d = rx_byte;
              if (cmd_q == CMD_UV_LIMIT) begin
                uv_limit_d = rx_byte & UV_LIMIT_WMASK; // [RULE_08] [RULE_15]
              end else if (byte_idx_q == 2'h1 && cmd_q == CMD_OV_LIMIT) begin
                ov_limit_d = {rx_byte, low_byte_q} & OV_LIMIT_WMASK; // [RULE_01] [RULE_15]
              end else if (byte_idx_q == 2'h1 && cmd_q == CMD_OC_LIMIT) begin
                oc_limit_d = {rx_byte, low_byte_q} & OC_LIMIT_WMASK; // [RULE_10] [RULE_15]
              end
            end
          end
        end
        S_WDATA_ACK: begin
          if (scl_fall) begin
            sda_oe_n_d = 1'b1;
            state_d    = S_WDATA;
          end
        end
        S_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt_q == BYTE_BITS - 4'h1) begin
              bit_cnt_d  = 4'h0;
              sda_oe_n_d = 1'b1;
              state_d    = S_RACK;
            end else begin
              bit_cnt_d  = bit_cnt_q + 4'h1;
              shift_d    = {shift_q[6:0], 1'b1};
              sda_oe_n_d = shift_q[6];
            end
          end
        end
        S_RACK: begin
          if (scl_rise) begin
            master_ack_d = ~sda_i;
          end else if (scl_fall) begin
            if (master_ack_q && (byte_idx_q + 2'h1) < fthr_cmd_bytes(cmd_q)) begin
              byte_idx_d = byte_idx_q + 2'h1;
              tx_byte    = fthr_rd_byte(cmd_q, cmd_hit_q, byte_idx_q + 2'h1, ov_limit_q,
                                        uv_limit_q, oc_limit_q);
              shift_d    = tx_byte;
              sda_oe_n_d = tx_byte[7];
              state_d    = S_RDATA;
            end else begin
              sda_oe_n_d = 1'b1;
              state_d    = S_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q      <= S_IDLE;
      scl_prev_q   <= 1'b1;
      sda_prev_q   <= 1'b1;
      bit_cnt_q    <= 4'h0;
      shift_q      <= 8'h00;
      cmd_q        <= 8'h00;
      cmd_hit_q    <= 1'b0;
      byte_idx_q   <= 2'h0;
      low_byte_q   <= 8'h00;
      master_ack_q <= 1'b0;
      sda_oe_n_q   <= 1'b1;
      ov_limit_q   <= OV_LIMIT_RESET; // [RULE_01]
      uv_limit_q   <= UV_LIMIT_RESET; // [RULE_08]
      oc_limit_q   <= OC_LIMIT_RESET; // [RULE_10]
    end else begin
      state_q      <= state_d;
      scl_prev_q   <= scl;
      sda_prev_q   <= sda_i;
      bit_cnt_q    <= bit_cnt_d;
      shift_q      <= shift_d;
      cmd_q        <= cmd_d;
      cmd_hit_q    <= cmd_hit_d;
      byte_idx_q   <= byte_idx_d;
      low_byte_q   <= low_byte_d;
      master_ack_q <= master_ack_d;
      sda_oe_n_q   <= sda_oe_n_d;
      ov_limit_q   <= ov_limit_d;
      uv_limit_q   <= uv_limit_d;
      oc_limit_q   <= oc_limit_d;
    end
  end

  // ==========================================================
  // limit fields to comparators
  fthr_limit_if lim ();

  assign lim.high_limit_source_select = ov_limit_q[SRC_SEL_BIT];
  assign lim.range_code               = ov_limit_q[RANGE_LSB +: RANGE_W];
  assign lim.high_limit_level         = ov_limit_q[LEVEL_W-1:0];
  assign lim.low_limit_level          = uv_limit_q[LEVEL_W-1:0];
  assign lim.shunt_dir                = oc_limit_q[DIR_BIT];
  assign lim.shunt_range              = oc_limit_q[SHUNT_RANGE_BIT];
  assign lim.shunt_limit_level        = oc_limit_q[LEVEL_W-1:0];

  logic high_trip;
  logic low_trip;
  logic shunt_trip;

  fthr_compare #(
    .VARIANT_60V (VARIANT_60V)
  ) u_compare (
    .ref_clk         (ref_clk),
    .rst             (rst),
    .lim             (lim),
    .bus_voltage_mv  (bus_voltage_mv),
    .die_temp_cc     (die_temp_cc),
    .shunt_input_pos (shunt_input_pos),
    .shunt_input_neg (shunt_input_neg),
    .high_trip_q     (high_trip),
    .low_trip_q      (low_trip),
    .shunt_trip_q    (shunt_trip)
  );

  // ==========================================================
  // alert pins, active low
  logic alert_one_oe_n_q;
  logic alert_one_oe_n_d;
  logic alert_two_n_q;
  logic alert_two_n_d;

  always_comb begin
    alert_one_oe_n_d = ~(high_trip | low_trip | shunt_trip); // [RULE_14]
    alert_two_n_d    = ~(high_trip | low_trip | shunt_trip); // [RULE_14]
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      alert_one_oe_n_q <= 1'b1;
      alert_two_n_q    <= 1'b1;
    end else begin
      alert_one_oe_n_q <= alert_one_oe_n_d;
      alert_two_n_q    <= alert_two_n_d;
    end
  end

  // open-drain pins only ever pull low
  logic zero_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      zero_q <= 1'b0;
    end else begin
      zero_q <= 1'b0;
    end
  end

  assign sda_o              = zero_q;
  assign sda_oe_n           = sda_oe_n_q;
  assign alert_out_one_o    = zero_q;
  assign alert_out_one_oe_n = alert_one_oe_n_q;
  assign alert_out_two_n    = alert_two_n_q;

endmodule

// >>> fthr_config_chk.sv
// port checks for the fault threshold bank and its alert pins
// assumes it is bound onto fthr_config
`timescale 1ns/10ps
module fthr_config_chk (
  input wire logic               ref_clk,
  input wire logic               rst,
  input wire logic               scl,
  input wire logic               sda_o,
  input wire logic               sda_oe_n,
  input wire logic [15:0]        bus_voltage_mv,
  input wire logic signed [15:0] die_temp_cc,
  input wire logic               alert_out_one_o,
  input wire logic               alert_out_one_oe_n,
  input wire logic               alert_out_two_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ========================================
  // bus data pin
  a_sda_low_only: assert property (sda_o == 1'b0) else $error("sda value not low");
  a_sda_high_hold: assert property (scl && $past(scl) |-> $stable(sda_oe_n))
    else $error("sda moved while scl high");
  a_sda_move_low: assert property ($changed(sda_oe_n) |-> !scl && !$past(scl))
    else $error("sda moved outside scl low");
  a_ack_min_len: assert property ($fell(sda_oe_n) |-> (!sda_oe_n) [*3])
    else $error("sda drive too short");
  // ========================================
  // alert pins
  a_reset_idle: assert property (disable iff (1'b0)
    rst |-> sda_oe_n && alert_out_one_oe_n && alert_out_two_n) else $error("pins not idle");
  a_od_low_only: assert property (alert_out_one_o == 1'b0) else $error("alert value");
  a_pins_agree: assert property (alert_out_one_oe_n == alert_out_two_n)
    else $error("alert pins differ");
  a_hot_alert: assert property (
    (bus_voltage_mv == 16'hffff && die_temp_cc == 16'sh7fff) [*3] |-> !alert_out_two_n)
    else $error("no alert on extreme inputs");
endmodule

// >>> fthr_host.sv
// host model for the serial management bus: scl and open-drain data
// assumes the bench forms the data wire from both enables with a pull-up
`timescale 1ns/10ps
module fthr_host #(
  parameter logic [6:0] ADDR = 7'h40
) (
  input  wire logic ref_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_oe_n
);
  initial begin
    scl = 1'b1;
    sda_oe_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // data moves only while scl is low
  task automatic xbit(input logic b, output logic r);
    tick(1);
    sda_oe_n = b;
    tick(2);
    scl = 1'b1;
    tick(3);
    r = sda;
    scl = 1'b0;
  endtask
  task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] r,
                       output logic k);
    for (int i = 7; i >= 0; i--) xbit(d[i], r[i]);
    xbit(a, k);
  endtask
  task automatic start();
    tick(1);
    sda_oe_n = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(3);
    sda_oe_n = 1'b0;
    tick(3);
    scl = 1'b0;
  endtask
  task automatic stop();
    tick(1);
    sda_oe_n = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(3);
    sda_oe_n = 1'b1;
    tick(3);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input int n, output logic nk);
    logic [7:0] r;
    logic       a0, a1, a2, a3;
    start();
    xbyte({ADDR, 1'b0}, 1'b1, r, a0);
    xbyte(c, 1'b1, r, a1);
    xbyte(d[7:0], 1'b1, r, a2);
    a3 = 1'b0;
    if (n == 2) xbyte(d[15:8], 1'b1, r, a3);
    stop();
    nk = a0 | a1 | a2 | a3;
  endtask
  // low byte first; master nacks the last byte
  task automatic rd(input logic [7:0] c, input int n, output logic [15:0] d);
    logic [7:0] r;
    logic       a;
    start();
    xbyte({ADDR, 1'b0}, 1'b1, r, a);
    xbyte(c, 1'b1, r, a);
    start();
    xbyte({ADDR, 1'b1}, 1'b1, r, a);
    d = 16'h0000;
    xbyte(8'hff, n == 1, d[7:0], a);
    if (n == 2) xbyte(8'hff, 1'b1, d[15:8], a);
    stop();
  endtask
endmodule

// >>> fthr_config_bench.sv
// self-checking bench for the fault threshold bank
// assumes fthr_host as bus partner and a pull-up on the data wire
`timescale 1ns/10ps
module fthr_config_bench;
  logic               ref_clk, rst, scl, host_oe_n, sda_o, sda_oe_n;
  wire logic          sda_w;
  logic [15:0]        bus_voltage_mv;
  logic signed [15:0] die_temp_cc;
  logic [26:0]        shunt_input_pos, shunt_input_neg;
  logic               alert_out_one_o, alert_out_one_oe_n, alert_out_two_n;
  int                 miscompares, checked, vin, tin, pin, nin;
  int                 fs60[8] = '{48000, 24000, 12000, 5000, 3300, 2500, 0, 0};
  logic [15:0]        ov_m, uv_m, oc_m;
  assign sda_w = sda_oe_n & host_oe_n;
  fthr_config #(.SLAVE_ADDR(7'h40), .VARIANT_60V(1'b1)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .scl(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .bus_voltage_mv(bus_voltage_mv), .die_temp_cc(die_temp_cc),
    .shunt_input_pos(shunt_input_pos), .shunt_input_neg(shunt_input_neg),
    .alert_out_one_o(alert_out_one_o), .alert_out_one_oe_n(alert_out_one_oe_n),
    .alert_out_two_n(alert_out_two_n));
  fthr_host #(.ADDR(7'h40)) host_u (
    .ref_clk(ref_clk), .sda(sda_w), .scl(scl), .sda_oe_n(host_oe_n));
  // ========================================
  // reference model
  function automatic logic pin_exp();
    int   fs, sfs, diff, hc;
    logic t;
    fs = fs60[ov_m[8:6]];
    hc = int'(ov_m[5:0]);
    if (ov_m[9]) t = tin > -14400 + 571 * hc;
    else t = fs != 0 && vin > fs * (16 + hc) / 64;
    if (fs != 0 && vin < fs * int'(uv_m[5:0]) / 64) t = 1'b1;
    sfs = oc_m[6] ? 40000 : 80000;
    diff = oc_m[9] ? nin - pin : pin - nin;
    if (diff > sfs * (16 + int'(oc_m[5:0])) / 64) t = 1'b1;
    return ~t;
  endfunction
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic drive(input int v, input int t, input int p, input int n);
    @(negedge ref_clk);
    vin = v;
    tin = t;
    pin = p;
    nin = n;
    bus_voltage_mv = v[15:0];
    die_temp_cc = t[15:0];
    shunt_input_pos = p[26:0];
    shunt_input_neg = n[26:0];
    repeat (3) @(negedge ref_clk);
    cmp({14'h0, alert_out_one_oe_n, alert_out_two_n}, {14'h0, {2{pin_exp()}}}, "alerts");
  endtask
  task automatic wreg(input logic [7:0] c, input logic [15:0] d);
    logic nk;
    host_u.wr(c, d, (c == 8'hdb) ? 1 : 2, nk);
    if (c == 8'hda) ov_m = d & 16'h03ff;
    if (c == 8'hdb) uv_m = d & 16'h003f;
    if (c == 8'hdc) oc_m = d & 16'h027f;
    cmp({15'h0, nk}, 16'h0000, "write nack");
  endtask
  task automatic rchk(input logic [7:0] c);
    logic [15:0] d;
    host_u.rd(c, (c == 8'hdb) ? 1 : 2, d);
    cmp(d, (c == 8'hda) ? ov_m : (c == 8'hdb) ? uv_m : oc_m, "readback");
  endtask
  task automatic complete_run();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ========================================
  // stimulus
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (90000) @(posedge ref_clk);
    miscompares++;
    complete_run();
  end
  initial begin
    int         c, r, thr;
    logic       nk;
    logic [7:0] cc;
    rst = 1'b1;
    miscompares = 0;
    checked = 0;
    {vin, tin, pin, nin} = '0;
    {bus_voltage_mv, die_temp_cc, shunt_input_pos, shunt_input_neg} = '0;
    ov_m = 16'h003f;
    uv_m = 16'h0000;
    oc_m = 16'h003f;
    void'($urandom(29));
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    rchk(8'hda);
    rchk(8'hdb);
    rchk(8'hdc);
    for (int i = 0; i < 6; i++) begin
      cc = 8'(8'hda + i % 3);
      wreg(cc, 16'($urandom));
      rchk(cc);
    end
    host_u.wr(8'hda, 16'h0155, 1, nk);
    rchk(8'hda);
    host_u.wr(8'hdd, 16'h1234, 2, nk);
    cmp({15'h0, nk}, 16'h0001, "unknown command");
    wreg(8'hdb, 16'h0000);
    wreg(8'hdc, 16'h003f);
    for (r = 0; r < 8; r++) begin
      c = $urandom % 64;
      wreg(8'hda, 16'(r * 64 + c));
      thr = fs60[r] * (16 + c) / 64;
      drive((r < 6) ? thr + 1 : 65535, 0, 0, 0);
      drive(thr, 0, 0, 0);
    end
    for (r = 0; r < 6; r++) begin
      c = 1 + $urandom % 63;
      wreg(8'hda, 16'(r * 64 + 63));
      wreg(8'hdb, 16'(c));
      thr = fs60[r] * c / 64;
      drive(thr - 1, 0, 0, 0);
      drive(thr, 0, 0, 0);
    end
    drive(65535, 32767, 0, 0);
    wreg(8'hdb, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      c = $urandom % 64;
      wreg(8'hda, 16'(512 + c));
      thr = -14400 + 571 * c;
      drive(65535, thr + 1, 0, 0);
      drive(65535, thr, 0, 0);
    end
    wreg(8'hda, 16'h003f);
    for (r = 0; r < 4; r++) begin
      c = $urandom % 64;
      wreg(8'hdc, 16'((r / 2) * 512 + (r % 2) * 64 + c));
      thr = ((r % 2) ? 40000 : 80000) * (16 + c) / 64;
      drive(1000, 0, thr + 1, 0);
      drive(1000, 0, 0, thr + 1);
      drive(1000, 0, thr, 0);
    end
    complete_run();
  end
endmodule
bind fthr_config fthr_config_chk chk_u (
  .ref_clk(ref_clk), .rst(rst), .scl(scl), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
  .bus_voltage_mv(bus_voltage_mv), .die_temp_cc(die_temp_cc),
  .alert_out_one_o(alert_out_one_o), .alert_out_one_oe_n(alert_out_one_oe_n),
  .alert_out_two_n(alert_out_two_n));
